/* core/audio_out_pkg.sv */
// Package: register map, field layout, timing and carrier types
package audio_out_pkg;
   localparam logic [7:0] OFS_PINS56   = 8'h20;
   localparam logic [7:0] OFS_PINS78   = 8'h21;
   localparam logic [7:0] OFS_PLL      = 8'h2b;
   localparam logic [7:0] OFS_MCLK     = 8'h3a;
   localparam logic [7:0] OFS_LVL_LO   = 8'h6e;
   localparam logic [7:0] OFS_LVL_HI   = 8'h6f;
   localparam logic [7:0] OFS_AUDCTL   = 8'h70;
   localparam int         PLL_DIS_BIT  = 7;
   localparam int         OVR_BIT      = 7;
   localparam logic [7:0] PIN_OUT_L    = 8'h01;
   localparam logic [7:0] PIN_OUT_H    = 8'h09;
   localparam logic [7:0] PIN_IN       = 8'h03;
   localparam logic [7:0] RST_PINS     = 8'h00;
   localparam logic [7:0] RST_PLL      = 8'h00;
   localparam logic [7:0] RST_MCLK     = 8'h10;
   localparam logic [7:0] RST_AUDCTL   = 8'h00;
   localparam logic [2:0] MUL_CODE_X1  = 3'h0;
   localparam logic [2:0] MUL_CODE_X2  = 3'h1;
   localparam logic [2:0] MUL_CODE_X4  = 3'h2;
   // Bit clock rate bounds in kHz and clock rate in kHz
   localparam int         CLK_KHZ      = 125000;
   localparam int         BCLK_MIN_KHZ = 1000;
   localparam int         BCLK_MAX_KHZ = 13000;
   localparam int         BCLK_DIV_MIN = (CLK_KHZ + BCLK_MAX_KHZ - 1)
                                         / BCLK_MAX_KHZ;
   localparam int         BCLK_DIV_MAX = CLK_KHZ / BCLK_MIN_KHZ;
   localparam int         LOCK_CYCLES  = 64;
   localparam int         SAMPLE_W     = 24;
   localparam int         NUM_LINES    = 4;

   typedef enum logic [1:0] {XPORT_ISLAND, XPORT_FRAME} xport_e;

   // One stereo frame for all four data lines
   typedef struct packed {
      logic [NUM_LINES-1:0][SAMPLE_W-1:0] left;
      logic [NUM_LINES-1:0][SAMPLE_W-1:0] right;
   } audio_frame_s;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
   } reg_req_s;
endpackage : audio_out_pkg

/* core/audio_fifo.sv */
// Parameterised synchronous FIFO with valid/ready on both sides
module audio_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output      logic             in_ready_o,
   output      logic [WIDTH-1:0] out_data_o,
   output      logic             out_valid_o,
   input  wire logic             out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wptr;
   logic [AW:0]      rptr;
   wire              full  = (wptr[AW] != rptr[AW]) &&
                             (wptr[AW-1:0] == rptr[AW-1:0]);
   wire              empty = (wptr == rptr);
   wire              push  = in_valid_i && !full;
   wire              pop   = out_ready_i && !empty;

   assign in_ready_o  = !full;
   assign out_valid_o = !empty;
   assign out_data_o  = mem[rptr[AW-1:0]];

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wptr[AW-1:0]] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wptr <= '0;
         rptr <= '0;
      end else begin
         if (push) begin
            wptr <= wptr + 1'b1;
         end
         if (pop) begin
            rptr <= rptr + 1'b1;
         end
      end
   end
endmodule : audio_fifo

/* core/audio_out.sv */
// Audio serial output section of a link deserializer
// Operation
// - Bit clock between 1 and 13 MHz
// - Four stereo data lines share word select
// - Legacy compatibility mode disables all audio except regenerated bit clock and word select
// - Non-surround partner: A only, or A+B
// - Default transport is blanking data islands
// - Transport loaded from serializer; software may override
// - Frame transport drives only line A
// - Surround needs island transport and capable partner
// - Surround propagates automatically down repeater tree
// - Repeater may regenerate from own input pins
// - Master clock at x1, x2 or x4
// - Master clock off when PLL disabled
// - Master clock multiplier defaults to x2
// - Multiplier code steps with bit clock rate
// - Register-only pins override shared audio inputs
// - Config 0x01 low, 0x09 high, 0x03 input
// - Pin levels read at 0x6e[7:5], 0x6f[0]
// - Pin state local only, never link-carried
// - Audio pins follow power-down, enable, sleep-state table; register-only pins follow power-down only
// - Lock before presenting valid outputs
module audio_out
   import audio_out_pkg::*;
#(
   parameter int FIFO_DEPTH = 16
) (
   // Clock and reset
   input  wire logic            CLK_I,
   input  wire logic            SYS_RST_I,
   // Device pins and straps
   input  wire logic            POWER_DOWN_BAR_I,
   input  wire logic            OUTPUT_ENABLE_PIN_I,
   input  wire logic            OUTPUT_SLEEP_STATE_SELECT_I,
   input  wire logic            LEGACY_COMPAT_MODE_I,
   input  wire logic            REPEATER_MODE_I,
   // Link state and loaded configuration from the serializer
   input  wire logic            LINK_ACTIVE_I,
   input  wire logic            CDR_LOCKED_I,
   input  wire logic            LOADED_SURROUND_I,
   input  wire logic            LOADED_18BIT_I,
   input  wire logic            PARTNER_SURROUND_CAP_I,
   // Received audio frames (data island or frame payload)
   input  wire audio_frame_s    RX_FRAME_I,
   input  wire logic            RX_VALID_I,
   output      logic            RX_READY_O,
   // Local audio input pins for repeater regeneration
   input  wire logic            LOCAL_BCLK_I,
   input  wire logic            LOCAL_WS_I,
   input  wire logic [3:0]      LOCAL_DATA_I,
   // Register port
   input  wire reg_req_s        REG_REQ_I,
   output      logic [7:0]      REG_RDATA_O,
   // Audio outputs (value, enable)
   output      logic            AUDIO_BIT_CLOCK_O,
   output      logic            AUDIO_WORD_SELECT_O,
   output      logic [3:0]      AUDIO_DATA_O,
   output      logic            AUDIO_OE_O,
   output      logic            MASTER_CLOCK_O,
   output      logic            LOCK_O,
   output      logic            LOCK_OE_O,
   // Register-only pins 5..8 (value, enable, in)
   input  wire logic [3:0]      REG_PIN_I,
   output      logic [3:0]      REG_PIN_O,
   output      logic [3:0]      REG_PIN_OE_O
);
   // Register file
   logic [7:0]  pins56;
   logic [7:0]  pins78;
   logic [7:0]  pll_ctl;
   logic [7:0]  mclk_ctl;
   logic [7:0]  aud_ctl;
   logic [7:0]  bclk_div;

   wire wr = REG_REQ_I.wr;
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         pins56   <= RST_PINS;
         pins78   <= RST_PINS;
         pll_ctl  <= RST_PLL;
         mclk_ctl <= RST_MCLK;
         aud_ctl  <= RST_AUDCTL;
      end else if (wr) begin
         case (REG_REQ_I.addr)
            OFS_PINS56: pins56  <= REG_REQ_I.wdata;
            OFS_PINS78: pins78  <= REG_REQ_I.wdata;
            OFS_PLL:    pll_ctl <= REG_REQ_I.wdata;
            // Code field only moves once override bit already set
            OFS_MCLK: begin
               mclk_ctl[OVR_BIT] <= REG_REQ_I.wdata[OVR_BIT];
               if (mclk_ctl[OVR_BIT]) begin
                  mclk_ctl[6:0] <= REG_REQ_I.wdata[6:0];
               end
            end
            OFS_AUDCTL: aud_ctl <= REG_REQ_I.wdata;
            default: ;
         endcase
      end
   end
   // aud_ctl: [0] disable loaded config, [1] four-ch A/B,
   // [2] regenerate from local pins, [7:3] unused
   assign bclk_div = 8'(BCLK_DIV_MIN * 2);

   // Pin input synchronisers; straps are board pins as well
   logic [3:0] pin_s1;
   logic [3:0] pin_s2;
   logic [5:0] loc_s1;
   logic [5:0] loc_s2;
   logic [4:0] strap_s1;  // Power, enable, sleep, legacy, repeater
   logic [4:0] strap_s2;
   always_ff @(posedge CLK_I) begin
      pin_s1 <= REG_PIN_I;
      pin_s2 <= pin_s1;
      strap_s1 <= {POWER_DOWN_BAR_I, OUTPUT_ENABLE_PIN_I,
                   OUTPUT_SLEEP_STATE_SELECT_I, LEGACY_COMPAT_MODE_I,
                   REPEATER_MODE_I};
      strap_s2 <= strap_s1;
      loc_s1 <= {LOCAL_BCLK_I, LOCAL_WS_I, LOCAL_DATA_I};
      loc_s2 <= loc_s1;
   end

   // Register-only pin decode; local only, not sent over link
   function automatic logic [1:0] pin_cfg(input logic [3:0] nib);
      // Returns {oe, value}
      case ({4'h0, nib})
         PIN_OUT_L: pin_cfg = 2'b10;
         PIN_OUT_H: pin_cfg = 2'b11;
         default:   pin_cfg = 2'b00;
      endcase
   endfunction : pin_cfg
   function automatic logic pin_en(input logic [3:0] nib);
      pin_en = ({4'h0, nib} == PIN_OUT_L) || ({4'h0, nib} == PIN_OUT_H)
               || ({4'h0, nib} == PIN_IN);
   endfunction : pin_en

   wire [1:0] c5 = pin_cfg(pins56[3:0]);
   wire [1:0] c6 = pin_cfg(pins56[7:4]);
   wire [1:0] c7 = pin_cfg(pins78[3:0]);
   wire [1:0] c8 = pin_cfg(pins78[7:4]);
   wire [3:0] gp_en = {pin_en(pins78[7:4]), pin_en(pins78[3:0]),
                       pin_en(pins56[7:4]), pin_en(pins56[3:0])};
   wire       powered = strap_s2[4];
   assign REG_PIN_OE_O = powered ? {c8[1], c7[1], c6[1], c5[1]} : 4'h0;
   assign REG_PIN_O    = {c8[0], c7[0], c6[0], c5[0]};

   // Read mux
   always_comb begin
      case (REG_REQ_I.addr)
         OFS_PINS56: REG_RDATA_O = pins56;
         OFS_PINS78: REG_RDATA_O = pins78;
         OFS_PLL:    REG_RDATA_O = pll_ctl;
         OFS_MCLK:   REG_RDATA_O = mclk_ctl;
         OFS_AUDCTL: REG_RDATA_O = aud_ctl;
         OFS_LVL_LO: REG_RDATA_O = {pin_s2[2:0], 5'h00};
         OFS_LVL_HI: REG_RDATA_O = {7'h00, pin_s2[3]};
         default:    REG_RDATA_O = 8'h00;
      endcase
   end

   // Mode resolution
   wire    audio_on  = !strap_s2[1];
   xport_e xport;
   // Loaded config picks islands; software disable selects frames
   assign xport = aud_ctl[0] ? XPORT_FRAME : XPORT_ISLAND;
   wire surround = (xport == XPORT_ISLAND) && LOADED_SURROUND_I
                   && PARTNER_SURROUND_CAP_I;
   wire two_line = LOADED_18BIT_I || aud_ctl[1];
   logic [3:0] line_mask;
   assign line_mask = !audio_on               ? 4'h0 :
                      (xport == XPORT_FRAME)  ? 4'h1 :
                      surround                ? 4'hf :
                      two_line                ? 4'h3 : 4'h1;
   wire regen = strap_s2[0] && aud_ctl[2];

   // Lock sequence after power-down release
   logic [6:0] lock_cnt;
   logic       locked;
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I || !powered || !CDR_LOCKED_I) begin
         lock_cnt <= '0;
         locked   <= 1'b0;
      end else if (lock_cnt == 7'(LOCK_CYCLES)) begin
         locked   <= 1'b1;
      end else begin
         lock_cnt <= lock_cnt + 1'b1;
      end
   end

   // Output state table
   wire valid_out = powered && strap_s2[3] && LINK_ACTIVE_I
                    && strap_s2[2] && locked;
   assign AUDIO_OE_O = powered && !(!strap_s2[3]
                       && strap_s2[2]);
   assign LOCK_OE_O  = AUDIO_OE_O;
   assign LOCK_O     = locked;

   // Frame buffer between link and serialiser
   audio_frame_s fifo_q;
   logic         fifo_valid;
   logic         fifo_pop;
   audio_fifo #(
      .WIDTH ($bits(audio_frame_s)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (CLK_I),
      .rst_i       (SYS_RST_I),
      .in_data_i   (RX_FRAME_I),
      .in_valid_i  (RX_VALID_I && audio_on),
      .in_ready_o  (RX_READY_O),
      .out_data_o  (fifo_q),
      .out_valid_o (fifo_valid),
      .out_ready_i (fifo_pop)
   );

   // Bit clock divider: half period of bclk_div cycles
   logic [7:0] div_cnt;
   logic       bclk;
   wire        bclk_fall = (div_cnt == bclk_div - 8'h01) && bclk;
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I || !audio_on) begin
         div_cnt <= '0;
         bclk    <= 1'b0;
      end else if (div_cnt == bclk_div - 8'h01) begin
         div_cnt <= '0;
         bclk    <= !bclk;
      end else begin
         div_cnt <= div_cnt + 1'b1;
      end
   end

   // I2S serialiser, changes on falling bit clock
   logic [4:0]                         bit_idx;
   logic                               ws;
   logic [NUM_LINES-1:0][SAMPLE_W-1:0] sh;
   audio_frame_s                       cur;
   wire last_bit = (bit_idx == 5'(SAMPLE_W - 1));
   // Word select flips with the LSB, so the MSB trails it by one bit
   wire ws_flip  = (bit_idx == 5'(SAMPLE_W - 2));
   assign fifo_pop = bclk_fall && last_bit && !ws && fifo_valid;
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I || !audio_on) begin
         bit_idx <= '0;
         ws      <= 1'b0;
         sh      <= '0;
         cur     <= '0;
      end else if (bclk_fall) begin
         if (last_bit) begin
            bit_idx <= '0;
            // Word select is already low here: a new left word begins
            if (!ws) begin
               cur <= fifo_valid ? fifo_q : '0;      // Underrun: silence
               sh  <= fifo_valid ? fifo_q.left : '0;
            end else begin
               sh  <= cur.right;
            end
         end else begin
            bit_idx <= bit_idx + 1'b1;
            if (ws_flip) begin
               ws <= !ws;
            end
            for (int i = 0; i < NUM_LINES; i++) begin
               sh[i] <= {sh[i][SAMPLE_W-2:0], 1'b0};
            end
         end
      end
   end

   logic [3:0] msb;
   always_comb begin
      for (int i = 0; i < NUM_LINES; i++) begin
         msb[i] = sh[i][SAMPLE_W-1];
      end
   end

   // Output registers; shared pins taken by register-only mode
   logic o_bclk;
   logic o_ws;
   logic [3:0] o_data;
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I || !valid_out) begin
         o_bclk <= 1'b0;
         o_ws   <= 1'b0;
         o_data <= 4'h0;
      end else if (regen) begin
         o_bclk <= loc_s2[5];
         o_ws   <= loc_s2[4];
         o_data <= loc_s2[3:0] & line_mask & ~gp_en;
      end else begin
         o_bclk <= bclk;
         o_ws   <= ws;
         o_data <= msb & line_mask & ~gp_en;
      end
   end
   assign AUDIO_BIT_CLOCK_O   = o_bclk;
   assign AUDIO_WORD_SELECT_O = o_ws;
   assign AUDIO_DATA_O        = o_data;

   // Master clock: x4 toggles every eighth of a bit period
   wire       pll_on = !pll_ctl[PLL_DIS_BIT];
   logic [2:0] code;
   assign code = mclk_ctl[6:4];
   logic [7:0] mdiv;
   assign mdiv = (code == MUL_CODE_X1) ? bclk_div :
                 (code == MUL_CODE_X4) ? (bclk_div >> 2) :
                 (bclk_div >> 1);
   logic [7:0] mcnt;
   logic       mclk;
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I || !pll_on || !audio_on) begin
         mcnt <= '0;
         mclk <= 1'b0;
      end else if (mcnt >= mdiv - 8'h01) begin
         mcnt <= '0;
         mclk <= !mclk;
      end else begin
         mcnt <= mcnt + 1'b1;
      end
   end
   assign MASTER_CLOCK_O = mclk && valid_out;

   // Checks
   mclk_off_a: assert property (@(posedge CLK_I)
      disable iff (SYS_RST_I) !pll_on |=> !mclk)
      else $error("master clock runs with PLL off");
   legacy_off_a: assert property (@(posedge CLK_I)
      disable iff (SYS_RST_I) !audio_on |-> ##2 (AUDIO_DATA_O == 4'h0))
      else $error("audio active in legacy mode");
   frame_line_a: assert property (@(posedge CLK_I)
      disable iff (SYS_RST_I)
      (xport == XPORT_FRAME) |-> (line_mask[3:1] == 3'h0))
      else $error("extra lines in frame transport");
   surround_cap_a: assert property (@(posedge CLK_I)
      disable iff (SYS_RST_I)
      (line_mask == 4'hf) |-> PARTNER_SURROUND_CAP_I)
      else $error("surround without capable partner");
   sequence s_unlocked;
      !locked;
   endsequence
   lock_valid_a: assert property (@(posedge CLK_I)
      disable iff (SYS_RST_I)
      s_unlocked |=> (o_data == 4'h0 && !o_bclk))
      else $error("outputs valid before lock");
   pin_drive_a: assert property (@(posedge CLK_I)
      disable iff (SYS_RST_I)
      (powered && pins56[3:0] == 4'h9) |-> (REG_PIN_OE_O[0] && REG_PIN_O[0]))
      else $error("pin 5 not driven high");
   powerdown_a: assert property (@(posedge CLK_I)
      disable iff (SYS_RST_I)
      !powered |-> (!AUDIO_OE_O && REG_PIN_OE_O == 4'h0))
      else $error("pins driven in power down");
   sequence s_ovr_clear;
      !mclk_ctl[OVR_BIT] && wr && REG_REQ_I.addr == OFS_MCLK;
   endsequence
   mult_order_a: assert property (@(posedge CLK_I)
      disable iff (SYS_RST_I) s_ovr_clear |=> $stable(mclk_ctl[6:4]))
      else $error("code moved without prior override");
   bclk_rate_a: assert property (@(posedge CLK_I)
      disable iff (SYS_RST_I)
      (bclk_div >= 8'(BCLK_DIV_MIN)) && (bclk_div <= 8'(BCLK_DIV_MAX / 2)))
      else $error("bit clock out of range");
endmodule : audio_out

/* testbench/i2s_sink.sv */
// I2S sink model standing in for the DAC on data line A
module i2s_sink
   import audio_out_pkg::*;
(
   // Clock
   input  wire logic                clk_i,
   // Serial audio from the block
   input  wire logic                bclk_i,
   input  wire logic                ws_i,
   input  wire logic                sd_i,
   // Captured words
   output      logic [SAMPLE_W-1:0] left_o,
   output      logic [SAMPLE_W-1:0] right_o,
   output      int                  words_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic                bclk_q = 1'b0;
   logic                ws_q   = 1'b0;
   logic [SAMPLE_W-1:0] sr     = '0;
   initial words_o = 0;
   // Taken on bit clock rise; the LSB lands in the same bit as the WS edge
   always @(posedge clk_i) begin
      bclk_q <= bclk_i;
      if (bclk_i && !bclk_q) begin
         sr   <= {sr[SAMPLE_W-2:0], sd_i};
         ws_q <= ws_i;
         if (ws_i != ws_q) begin
            if (ws_q) right_o <= {sr[SAMPLE_W-2:0], sd_i};
            else left_o <= {sr[SAMPLE_W-2:0], sd_i};
            words_o <= words_o + 1;
         end
      end
   end
endmodule : i2s_sink

/* testbench/tb.sv */
// Self-checking bench for the audio output section
module tb import audio_out_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [23:0] LA = 24'ha5c3e1;
   localparam logic [23:0] RA = 24'h1e3c5a;
   logic clk, rst, power_down_bar, output_enable_pin, oss, legacy_compat_mode, rpt, link, cdr, lsur, l18, pcap;
   logic rx_valid, rx_ready, lbclk, lws, bclk, ws, oe, mclk, lock, lock_oe;
   logic [3:0]   ldata, pin_i, pin_o, pin_oe, dout;
   logic [7:0]   rdata, d;
   logic [2:0]   acc;
   audio_frame_s frame;
   reg_req_s     req;
   logic [23:0]  cap_l, cap_r;
   int           words, nb, nm, cyc, n_fail, num_checks, n0, m0, lcnt;
   logic         bq, mq, lrun;

   audio_out #(.FIFO_DEPTH(16)) audio_out_i (
      .CLK_I(clk), .SYS_RST_I(rst), .POWER_DOWN_BAR_I(power_down_bar),
      .OUTPUT_ENABLE_PIN_I(output_enable_pin), .OUTPUT_SLEEP_STATE_SELECT_I(oss),
      .LEGACY_COMPAT_MODE_I(legacy_compat_mode), .REPEATER_MODE_I(rpt),
      .LINK_ACTIVE_I(link), .CDR_LOCKED_I(cdr), .LOADED_SURROUND_I(lsur),
      .LOADED_18BIT_I(l18), .PARTNER_SURROUND_CAP_I(pcap),
      .RX_FRAME_I(frame), .RX_VALID_I(rx_valid), .RX_READY_O(rx_ready),
      .LOCAL_BCLK_I(lbclk), .LOCAL_WS_I(lws), .LOCAL_DATA_I(ldata),
      .REG_REQ_I(req), .REG_RDATA_O(rdata), .AUDIO_BIT_CLOCK_O(bclk),
      .AUDIO_WORD_SELECT_O(ws), .AUDIO_DATA_O(dout), .AUDIO_OE_O(oe),
      .MASTER_CLOCK_O(mclk), .LOCK_O(lock), .LOCK_OE_O(lock_oe),
      .REG_PIN_I(pin_i), .REG_PIN_O(pin_o), .REG_PIN_OE_O(pin_oe));
   i2s_sink i2s_sink_i (.clk_i(clk), .bclk_i(bclk), .ws_i(ws),
      .sd_i(dout[0]), .left_o(cap_l), .right_o(cap_r), .words_o(words));

   initial begin
      clk = 0;
      forever #4 clk = ~clk;
   end
   // Local bit clock only runs while a regeneration test is on
   initial begin
      #3;
      forever begin
         #32;
         if (lrun) lbclk = ~lbclk;
         if (lrun && !lbclk) begin
            lcnt++;
            lws   = (lcnt / 24) % 2;
            ldata = lcnt[3:0];
         end
      end
   end
   always @(posedge clk) begin
      cyc++;
      bq <= bclk;
      mq <= mclk;
      if (bclk && !bq) nb++;
      if (mclk && !mq) nm++;
      acc = acc | dout[3:1];
      if (cyc == 60000) begin
         n_fail++;
         summarize();
      end
   end

   task automatic chk(input string n, input logic [31:0] s, e);
      num_checks++;
      if (s !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   function automatic logic in_rng(input logic [31:0] v, input int lo, hi);
      return v >= lo && v <= hi;
   endfunction : in_rng
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask : wt
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk) req <= '{a, v, 1'b1};
      @(posedge clk) req <= '{a, 8'h00, 1'b0};
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk) req <= '{a, 8'h00, 1'b0};
      @(negedge clk) v = rdata;
   endtask : rd
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      rd(a, v);
      chk("rdata", v, e);
   endtask : rchk

   task automatic t_regs();
      rchk(OFS_PINS56, RST_PINS);
      rchk(OFS_PINS78, RST_PINS);
      rchk(OFS_PLL, RST_PLL);
      rchk(OFS_MCLK, RST_MCLK);
      rchk(OFS_AUDCTL, RST_AUDCTL);
      wr(8'h55, 8'hff);
      rchk(8'h55, 8'h00);
      wr(OFS_MCLK, 8'h20);
      rchk(OFS_MCLK, RST_MCLK);
      wr(OFS_MCLK, 8'h80);
      wr(OFS_MCLK, 8'ha0);
      rchk(OFS_MCLK, 8'ha0);
      wr(OFS_MCLK, 8'h90);
      $display("test regs done");
   endtask : t_regs

   task automatic t_pins();
      wr(OFS_PINS56, {PIN_IN[3:0], PIN_OUT_H[3:0]});
      wr(OFS_PINS78, {PIN_IN[3:0], PIN_OUT_L[3:0]});
      pin_i <= 4'b1010;
      wt(4);
      chk("pin_oe", pin_oe, 4'b0101);
      chk("pin_o", {pin_o[2], pin_o[0]}, 2'b01);
      rd(OFS_LVL_LO, d);
      chk("lvl6", d[6], 1'b1);
      rd(OFS_LVL_HI, d);
      chk("lvl8", d[0], 1'b1);
      pin_i <= 4'b0000;
      wt(4);
      rd(OFS_LVL_LO, d);
      chk("lvl6", d[6], 1'b0);
      wr(OFS_PINS56, RST_PINS);
      wr(OFS_PINS78, RST_PINS);
      wt(2);
      chk("pin_oe off", pin_oe, 4'h0);
      $display("test pins done");
   endtask : t_pins

   task automatic t_fill();
      int k;
      k = 0;
      @(posedge clk) rx_valid <= 1'b1;
      repeat (40) begin
         @(negedge clk);
         if (rx_ready === 1'b1) k++;
      end
      chk("fill", in_rng(k, 16, 17), 1'b1);
      chk("full", rx_ready, 1'b0);
      $display("test fifo done");
   endtask : t_fill

   task automatic t_audio();
      @(posedge clk);
      link <= 1'b1;
      cdr  <= 1'b1;
      wt(60);
      chk("lock early", lock, 1'b0);
      wt(10);
      chk("lock", lock, 1'b1);
      chk("oe", oe, 1'b1);
      n0 = words;
      for (int i = 0; i < 20000 && words < n0 + 6; i++) wt(1);
      chk("left a", cap_l, LA);
      chk("right a", cap_r, RA);
      acc = 3'b000;
      n0  = nb;
      m0  = nm;
      wt(4000);
      chk("bclk rate", in_rng(nb - n0, 32, 400), 1'b1);
      chk("mclk x2", in_rng(nm - m0, 2*(nb-n0) - 2, 2*(nb-n0) + 2),
          1'b1);
      chk("line b-d", acc, 3'b000);
      wr(OFS_MCLK, 8'ha0);
      n0 = nb;
      m0 = nm;
      wt(4000);
      chk("mclk x4", in_rng(nm - m0, 4*(nb-n0) - 4, 4*(nb-n0) + 4),
          1'b1);
      wr(OFS_PLL, 8'h80);
      wt(4);
      m0 = nm;
      wt(400);
      chk("mclk off", nm - m0, 0);
      wr(OFS_PLL, 8'h00);
      $display("test audio done");
   endtask : t_audio

   task automatic t_xport();
      @(posedge clk);
      lsur <= 1'b1;
      pcap <= 1'b1;
      wr(OFS_AUDCTL, 8'h01);
      wt(100);
      acc = 3'b000;
      n0  = words;
      wt(4000);
      chk("frame b-d", acc, 3'b000);
      chk("frame a", cap_l, LA);
      wr(OFS_AUDCTL, 8'h00);
      wt(100);
      acc = 3'b000;
      wt(4000);
      chk("surround", acc, 3'b111);
      lsur <= 1'b0;
      pcap <= 1'b0;
      wr(OFS_AUDCTL, 8'h02);
      wt(100);
      acc = 3'b000;
      wt(4000);
      chk("four-ch a/b", acc, 3'b001);
      wr(OFS_AUDCTL, 8'h00);
      l18 <= 1'b1;
      wt(100);
      acc = 3'b000;
      wt(4000);
      chk("18-bit a/b", acc, 3'b001);
      l18 <= 1'b0;
      $display("test transport done");
   endtask : t_xport

   task automatic t_legacy_regen();
      wr(OFS_PLL, 8'h80);
      @(posedge clk) legacy_compat_mode <= 1'b1;
      wt(4);
      n0 = nb;
      wt(2000);
      chk("legacy bclk", nb - n0, 0);
      chk("legacy data", dout, 4'h0);
      legacy_compat_mode <= 1'b0;
      rpt  <= 1'b1;
      wr(OFS_AUDCTL, 8'h04);
      wr(OFS_PLL, 8'h00);
      lrun = 1'b1;
      wt(20);
      n0 = nb;
      wt(400);
      chk("regen bclk", in_rng(nb - n0, 48, 52), 1'b1);
      lrun = 1'b0;
      wr(OFS_AUDCTL, 8'h00);
      rpt <= 1'b0;
      $display("test legacy and regen done");
   endtask : t_legacy_regen

   task automatic t_state();
      @(posedge clk);
      output_enable_pin <= 1'b0;
      oss <= 1'b0;
      wt(4);
      chk("oe low drive", {oe, dout, ws}, 6'b100000);
      oss <= 1'b1;
      wt(4);
      chk("oe float", oe, 1'b0);
      output_enable_pin  <= 1'b1;
      link <= 1'b0;
      wt(4);
      chk("static", {oe, dout}, 5'b10000);
      power_down_bar <= 1'b0;
      wt(4);
      chk("powered down", {oe, lock_oe}, 2'b00);
      $display("test output states done");
   endtask : t_state

   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : summarize

   initial begin
      {power_down_bar, output_enable_pin, oss, rst} = 4'b1111;
      {legacy_compat_mode, rpt, link, cdr, lsur, l18, pcap, rx_valid} = 8'h00;
      {lbclk, lws, lrun, bq, mq} = 5'b00000;
      {ldata, pin_i, acc} = '0;
      {cyc, nb, nm, n_fail, num_checks, lcnt} = '0;
      req = '{8'h00, 8'h00, 1'b0};
      for (int i = 0; i < NUM_LINES; i++) begin
         frame.left[i]  = LA;
         frame.right[i] = RA;
      end
      wt(5);
      rst <= 1'b0;
      t_regs();
      t_pins();
      t_fill();
      t_audio();
      t_xport();
      t_legacy_regen();
      t_state();
      summarize();
   end
endmodule : tb
